//--- siwc_pkg.sv
// shared constants, register map and carrier types of the sub-idle wake control
package siwc_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned STRB_W = 4;

	localparam logic [ADDR_W-1:0] OFF_STANDBY_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_CLK_SELECT   = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_STATUS       = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_WAKE_CAUSE   = 12'h00c;

	// standby_ctrl_reg field positions
	localparam int unsigned BIT_IDLE_VS_STOP = 0;
	localparam int unsigned BIT_STANDBY_REQ  = 1;
	localparam int unsigned BIT_PIN_NMI_MASK = 2;
	localparam int unsigned BIT_WDT_NMI_MASK = 3;
	localparam int unsigned BIT_MASKABLE_MSK = 4;
	localparam int unsigned CTRL_W           = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

	localparam int unsigned CLKSEL_W = 13;
	localparam logic [CLKSEL_W-1:0] CLKSEL_RESET = 13'h0000;

	// power_mode_select_reg value that picks idle rather than stop
	localparam logic SELECT_IDLE = 1'b0;

	// wake cause codes
	localparam logic [1:0] CAUSE_NONE     = 2'h0;
	localparam logic [1:0] CAUSE_PIN_NMI  = 2'h1;
	localparam logic [1:0] CAUSE_WDT_NMI  = 2'h2;
	localparam logic [1:0] CAUSE_MASKABLE = 2'h3;

	typedef enum logic [1:0]
	{
		ST_RUN      = 2'b00,
		ST_SUB_IDLE = 2'b01,
		ST_WAKE     = 2'b10
	} siwc_state_type;

	// count-source selections of the peripherals that may run in sub-idle
	typedef struct packed
	{
		logic       rto_uses_byte_timer_b;
		logic       rto_trig_byte_timer_irq;
		logic       async0_ext_baud;
		logic [2:0] serial_ext_clock;
		logic       interval_timer_b_fr_2048;
		logic       byte_timer_b_from_compare;
		logic       byte_timer_b_ext_input;
		logic       byte_timer_a_from_compare;
		logic       byte_timer_a_ext_input;
		logic       watch_timer_on_subclock;
		logic       wide_timer_one_from_watch_irq;
	} siwc_clksel_type;

	// clock-run enables handed to each peripheral
	typedef struct packed
	{
		logic       cpu;
		logic       intc;
		logic       wdt_one;
		logic       wdt_two;
		logic       capture_timer;
		logic       adc;
		logic       key_irq;
		logic       wide_timer_one;
		logic       other_wide_timers;
		logic [1:0] byte_timer;
		logic       interval_timer_a;
		logic       interval_timer_b;
		logic       watch_timer;
		logic [2:0] serial_sync;
		logic       serial_auto;
		logic       two_wire;
		logic       async0;
		logic       async12;
		logic       rto;
		logic       dac_drive;
		logic       dac_update;
	} siwc_run_type;

	localparam int unsigned RUN_W = 24;
	localparam logic [RUN_W-1:0] RUN_ALL = 24'hffffff;

	// wake decision handed to the core
	typedef struct packed
	{
		logic       branch;
		logic       resume_next;
		logic       acked_nmi;
		logic [1:0] cause;
	} siwc_wake_type;

endpackage : siwc_pkg

//--- siwc_sync.sv
// two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module siwc_sync
#(
	parameter int unsigned WIDTH = 1
)
(
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta;

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			meta   <= '0;
			o_sync <= '0;
		end
		else
		begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end

endmodule : siwc_sync

`default_nettype wire

//--- siwc_wake_arb.sv
// picks the most urgent unmasked maskable request; a lower code is more urgent
`timescale 1ns/1ps
`default_nettype none

module siwc_wake_arb
#(
	parameter int unsigned N_IRQ  = 8,
	parameter int unsigned PRIO_W = 3,
	parameter int unsigned IDX_W  = 3
)
(
	input  wire logic [N_IRQ-1:0]        i_req,
	input  wire logic [N_IRQ-1:0]        i_mask,
	input  wire logic [N_IRQ*PRIO_W-1:0] i_prio,
	output logic                         o_any,
	output logic      [IDX_W-1:0]        o_idx,
	output logic      [PRIO_W-1:0]       o_prio
);

	always_comb
	begin
		o_any  = 1'b0;
		o_idx  = '0;
		o_prio = '1;
		for (int i = 0; i < N_IRQ; i++)
		begin
			if (i_req[i] && !i_mask[i]
				&& (!o_any || i_prio[i*PRIO_W +: PRIO_W] < o_prio))
			begin
				o_any  = 1'b1;
				o_idx  = IDX_W'(i);
				o_prio = i_prio[i*PRIO_W +: PRIO_W];
			end
		end
	end

endmodule : siwc_wake_arb

`default_nettype wire

//--- siwc_top.sv
// sub-idle entry, wake arbitration and peripheral run enables behind an apb slave
// Contract
// R01: idle select plus stop request enters sub-idle
// R02: interrupt wake returns subclock, reset returns normal
// R03: nmi or unmasked request wakes regardless priority
// R04: lower-priority request wakes but is not acknowledged
// R05: unacknowledged waking request stays pending
// R06: higher-priority or nmi request is acknowledged
// R07: nmi wake branches to handler always
// R08: maskable wake with enable: branch or continue
// R09: maskable wake with disable: continue, no branch
// R10: wake-masked sources ignored, stay in sub-idle
// R11: reset during sub-idle acts as ordinary reset
// R12: wide timer one runs on watch irq source
// R13: byte timers run on pin or compare
// R14: interval timer b runs on fr/2048 only
// R15: watch timer needs subclock when main stopped
// R16: sync serial needs external clock; others stop
// R17: async channel 0 needs external baud clock
// R18: real-time output needs running byte timer trigger
// R19: dac keeps driving, value frozen
// R20: cpu, intc, wdt1, capture, adc stop; key, wdt2 run
`timescale 1ns/1ps
`default_nettype none

module siwc_top
#(
	parameter int unsigned N_IRQ  = 8,
	parameter int unsigned PRIO_W = 3,
	parameter int unsigned IDX_W  = 3
)
(
	input  wire logic                           i_clk,
	input  wire logic                           i_sys_rst,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [siwc_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [siwc_pkg::DATA_W-1:0]    pwdata,
	input  wire logic [siwc_pkg::STRB_W-1:0]    pstrb,
	output logic      [siwc_pkg::DATA_W-1:0]    prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire logic                           i_subclock_mode,
	input  wire logic                           i_main_clk_stopped,
	input  wire logic                           i_pin_nmi_req,
	input  wire logic                           i_wdt_nmi_req,
	input  wire logic [N_IRQ-1:0]               i_irq_req,
	input  wire logic [N_IRQ-1:0]               i_irq_mask,
	input  wire logic [N_IRQ*PRIO_W-1:0]        i_irq_prio,
	input  wire logic                           i_in_service,
	input  wire logic [PRIO_W-1:0]              i_service_prio,
	input  wire logic                           i_irq_globally_on,
	output logic                                o_in_sub_idle,
	output logic                                o_return_subclock,
	output logic                                o_wake,
	output siwc_pkg::siwc_wake_type             o_wake_info,
	output logic                                o_ack,
	output logic      [IDX_W-1:0]               o_ack_idx,
	output siwc_pkg::siwc_run_type              o_run
);

	siwc_pkg::siwc_state_type  state;
	siwc_pkg::siwc_state_type  next_state;
	logic [siwc_pkg::CTRL_W-1:0] ctrl;
	siwc_pkg::siwc_clksel_type clksel;
	logic [1:0]                last_cause;
	logic                      pin_nmi;
	logic                      any_req;
	logic [IDX_W-1:0]          best_idx;
	logic [PRIO_W-1:0]         best_prio;
	logic                      wr_en;
	logic                      rd_en;
	logic                      mapped;
	logic                      enter_req;
	logic                      wake_pin_nmi;
	logic                      wake_wdt_nmi;
	logic                      wake_maskable;
	logic                      wake_any;
	logic                      outranks;
	logic                      wt_run;
	logic                      wt1_run;
	logic [1:0]                bt_run;
	siwc_pkg::siwc_run_type    idle_run;

	function automatic logic [siwc_pkg::DATA_W-1:0] apply_strb
	(
		input logic [siwc_pkg::DATA_W-1:0] old_v,
		input logic [siwc_pkg::DATA_W-1:0] new_v,
		input logic [siwc_pkg::STRB_W-1:0] strb
	);
		logic [siwc_pkg::DATA_W-1:0] res;
		res = old_v;
		for (int b = 0; b < siwc_pkg::STRB_W; b++)
		begin
			if (strb[b])
			begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction : apply_strb

	// the pin nmi comes from outside the clock domain
	siwc_sync #(.WIDTH(1)) u_nmi_sync
	(
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   (i_pin_nmi_req),
		.o_sync    (pin_nmi)
	);

	siwc_wake_arb #(.N_IRQ(N_IRQ), .PRIO_W(PRIO_W), .IDX_W(IDX_W)) u_arb
	(
		.i_req  (i_irq_req),
		.i_mask (i_irq_mask),
		.i_prio (i_irq_prio),
		.o_any  (any_req),
		.o_idx  (best_idx),
		.o_prio (best_prio)
	);

	// apb decode, zero wait states
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign mapped  = (paddr == siwc_pkg::OFF_STANDBY_CTRL) || (paddr == siwc_pkg::OFF_CLK_SELECT)
		|| (paddr == siwc_pkg::OFF_STATUS) || (paddr == siwc_pkg::OFF_WAKE_CAUSE);
	assign pslverr = psel && penable && !mapped;

	// R01: stop request with idle selected
	assign enter_req = wr_en && (paddr == siwc_pkg::OFF_STANDBY_CTRL) && pstrb[0]
		&& pwdata[siwc_pkg::BIT_STANDBY_REQ] && i_subclock_mode
		&& (pwdata[siwc_pkg::BIT_IDLE_VS_STOP] == siwc_pkg::SELECT_IDLE);

	// R10: wake masks gate each source
	assign wake_pin_nmi  = pin_nmi && !ctrl[siwc_pkg::BIT_PIN_NMI_MASK];
	assign wake_wdt_nmi  = i_wdt_nmi_req && !ctrl[siwc_pkg::BIT_WDT_NMI_MASK];
	assign wake_maskable = any_req && !ctrl[siwc_pkg::BIT_MASKABLE_MSK];
	// R03: priority plays no part in waking
	assign wake_any      = wake_pin_nmi || wake_wdt_nmi || wake_maskable;
	// R04: only a request above the one in service is taken
	assign outranks      = !i_in_service || (best_prio < i_service_prio);

	always_comb
	begin
		next_state = state;
		unique case (state)
			siwc_pkg::ST_RUN:
			begin
				if (enter_req)
				begin
					next_state = siwc_pkg::ST_SUB_IDLE;
				end
			end
			siwc_pkg::ST_SUB_IDLE:
			begin
				if (wake_any)
				begin
					next_state = siwc_pkg::ST_WAKE;
				end
			end
			siwc_pkg::ST_WAKE:
			begin
				next_state = siwc_pkg::ST_RUN;
			end
			default:
			begin
				next_state = siwc_pkg::ST_RUN;
			end
		endcase
	end

	// R11: reset in any state runs the ordinary reset path
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			state <= siwc_pkg::ST_RUN;
		end
		else
		begin
			state <= next_state;
		end
	end

	// R02: reset returns normal mode, an interrupt wake returns subclock
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_return_subclock <= 1'b0;
		end
		else if (state == siwc_pkg::ST_SUB_IDLE && wake_any)
		begin
			o_return_subclock <= 1'b1;
		end
		else if (!i_subclock_mode)
		begin
			o_return_subclock <= 1'b0;
		end
	end

	// wake decision, registered into the one-cycle wake state
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_wake      <= 1'b0;
			o_wake_info <= '0;
			o_ack       <= 1'b0;
			o_ack_idx   <= '0;
		end
		else if (state == siwc_pkg::ST_SUB_IDLE && wake_any)
		begin
			o_wake <= 1'b1;
			if (wake_pin_nmi || wake_wdt_nmi)
			begin
				// R06: nmi is always taken
				// R07: nmi branches whatever the global enable
				o_wake_info.branch      <= 1'b1;
				o_wake_info.resume_next <= 1'b0;
				o_wake_info.acked_nmi   <= 1'b1;
				o_wake_info.cause       <= wake_pin_nmi ? siwc_pkg::CAUSE_PIN_NMI
					: siwc_pkg::CAUSE_WDT_NMI;
				o_ack                   <= 1'b0;
			end
			else
			begin
				// R08: enabled and outranking gives a branch, else continue
				// R09: disabled never branches
				o_wake_info.branch      <= i_irq_globally_on && outranks;
				o_wake_info.resume_next <= !(i_irq_globally_on && outranks);
				o_wake_info.acked_nmi   <= 1'b0;
				o_wake_info.cause       <= siwc_pkg::CAUSE_MASKABLE;
				// R05: no ack pulse, so the source keeps its request
				o_ack                   <= i_irq_globally_on && outranks;
			end
			o_ack_idx <= best_idx;
		end
		else
		begin
			o_wake      <= 1'b0;
			o_wake_info <= '0;
			o_ack       <= 1'b0;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			last_cause <= siwc_pkg::CAUSE_NONE;
		end
		else if (o_wake)
		begin
			last_cause <= o_wake_info.cause;
		end
	end

	// control registers; the stop request bit is not stored
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			ctrl   <= siwc_pkg::CTRL_RESET;
			clksel <= siwc_pkg::CLKSEL_RESET;
		end
		else if (wr_en && paddr == siwc_pkg::OFF_STANDBY_CTRL)
		begin
			ctrl <= siwc_pkg::CTRL_W'(apply_strb(siwc_pkg::DATA_W'(ctrl), pwdata, pstrb))
				& ~(siwc_pkg::CTRL_W'(1) << siwc_pkg::BIT_STANDBY_REQ);
		end
		else if (wr_en && paddr == siwc_pkg::OFF_CLK_SELECT)
		begin
			clksel <= siwc_pkg::CLKSEL_W'(apply_strb(siwc_pkg::DATA_W'(clksel), pwdata,
				pstrb));
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			prdata <= '0;
		end
		else if (rd_en)
		begin
			unique case (paddr)
				siwc_pkg::OFF_STANDBY_CTRL: prdata <= siwc_pkg::DATA_W'(ctrl);
				siwc_pkg::OFF_CLK_SELECT:   prdata <= siwc_pkg::DATA_W'(clksel);
				siwc_pkg::OFF_STATUS:       prdata <= {1'b0, o_run, 3'h0, o_return_subclock,
					o_in_sub_idle, state};
				siwc_pkg::OFF_WAKE_CAUSE:   prdata <= siwc_pkg::DATA_W'(last_cause);
				default:                    prdata <= '0;
			endcase
		end
	end

	// R15: watch timer on subclock when main clock is stopped
	assign wt_run  = !i_main_clk_stopped || clksel.watch_timer_on_subclock;
	// R12: wide timer one counts watch irq only
	assign wt1_run = clksel.wide_timer_one_from_watch_irq && wt_run;
	// R13: byte timers from pin or compare irq
	assign bt_run[0] = clksel.byte_timer_a_ext_input
		|| (clksel.byte_timer_a_from_compare && wt1_run);
	assign bt_run[1] = clksel.byte_timer_b_ext_input
		|| (clksel.byte_timer_b_from_compare && wt1_run);

	always_comb
	begin
		idle_run = '0;
		// R20: key interrupt and second watchdog keep running
		idle_run.key_irq          = 1'b1;
		idle_run.wdt_two          = 1'b1;
		idle_run.wide_timer_one   = wt1_run;
		idle_run.byte_timer       = bt_run;
		// R14: interval timer b on fr/2048, timer a stops
		idle_run.interval_timer_b = clksel.interval_timer_b_fr_2048;
		idle_run.watch_timer      = wt_run;
		// R16: sync channels on external clock only
		idle_run.serial_sync      = clksel.serial_ext_clock;
		// R17: async channel 0 on external baud clock
		idle_run.async0           = clksel.async0_ext_baud;
		// R18: trigger timer must be running
		idle_run.rto              = clksel.rto_trig_byte_timer_irq
			&& (clksel.rto_uses_byte_timer_b ? bt_run[1] : bt_run[0]);
		// R19: output driven, value frozen
		idle_run.dac_drive        = 1'b1;
		idle_run.dac_update       = 1'b0;
	end

	// R01: clocks gated only while in sub-idle
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_run         <= siwc_pkg::RUN_ALL;
			o_in_sub_idle <= 1'b0;
		end
		else if (next_state == siwc_pkg::ST_SUB_IDLE)
		begin
			o_run         <= idle_run;
			o_in_sub_idle <= 1'b1;
		end
		else
		begin
			o_run         <= siwc_pkg::RUN_ALL;
			o_in_sub_idle <= 1'b0;
		end
	end

endmodule : siwc_top

`default_nettype wire

//--- siwc_sva.sv
// concurrent checks on the sub-idle wake control ports
`timescale 1ns/1ps
`default_nettype none
module siwc_sva
(
	input wire logic	i_clk,
	input wire logic	i_sys_rst,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [siwc_pkg::ADDR_W-1:0]	paddr,
	input wire logic [siwc_pkg::DATA_W-1:0]	pwdata,
	input wire logic [siwc_pkg::STRB_W-1:0]	pstrb,
	input wire logic	i_subclock_mode,
	input wire logic	i_irq_globally_on,
	input wire logic	o_in_sub_idle,
	input wire logic	o_return_subclock,
	input wire logic	o_wake,
	input wire siwc_pkg::siwc_wake_type	o_wake_info,
	input wire logic	o_ack,
	input wire siwc_pkg::siwc_run_type	o_run
);
	wire logic	wake_msk = o_wake && o_wake_info.cause == siwc_pkg::CAUSE_MASKABLE;
	wire logic	wake_nmi = o_wake && o_wake_info.cause inside {2'h1, 2'h2};
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	property p_entry;
		$rose(o_in_sub_idle) |-> $past(psel && penable && pwrite && pstrb[0] && i_subclock_mode
			&& paddr == siwc_pkg::OFF_STANDBY_CTRL && pwdata[1:0] == 2'b10);
	endproperty
	a_entry: assert property (p_entry) else $error("sub-idle entered without request");
	property p_return;
		o_wake |-> o_return_subclock && !o_in_sub_idle;
	endproperty
	a_return: assert property (p_return) else $error("wake did not return to subclock");
	property p_awake;
		!o_in_sub_idle |-> o_run == siwc_pkg::RUN_ALL;
	endproperty
	a_awake: assert property (p_awake) else $error("run enables low while awake");
	property p_from_idle;
		o_wake |-> $past(o_in_sub_idle);
	endproperty
	a_from_idle: assert property (p_from_idle) else $error("wake outside sub-idle");
	property p_nmi;
		wake_nmi |-> o_wake_info.branch && o_wake_info.acked_nmi && !o_ack;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi wake without branch");
	property p_off;
		wake_msk && !$past(i_irq_globally_on) |-> !o_wake_info.branch && !o_ack;
	endproperty
	a_off: assert property (p_off) else $error("branch while interrupts off");
	property p_ack;
		wake_msk |-> o_ack == o_wake_info.branch && o_wake_info.resume_next != o_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack and branch disagree");
	property p_pulse;
		o_ack |-> o_wake ##1 !o_ack && !o_wake;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ack not a wake pulse");
	property p_stop;
		o_in_sub_idle |-> !(o_run.cpu || o_run.intc || o_run.wdt_one || o_run.capture_timer
			|| o_run.adc || o_run.serial_auto || o_run.two_wire || o_run.async12)
			&& o_run.key_irq && o_run.wdt_two;
	endproperty
	a_stop: assert property (p_stop) else $error("stopped unit still running");
	property p_dac;
		o_in_sub_idle |-> o_run.dac_drive && !o_run.dac_update && !o_run.interval_timer_a;
	endproperty
	a_dac: assert property (p_dac) else $error("converter enables wrong");
endmodule : siwc_sva
bind siwc_top siwc_sva u_sva
(
	.i_clk, .i_sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .i_subclock_mode,
	.i_irq_globally_on, .o_in_sub_idle, .o_return_subclock, .o_wake, .o_wake_info, .o_ack,
	.o_run
);
`default_nettype wire

//--- siwc_irq_src.sv
// interrupt sources that hold each request level until it is acknowledged
`timescale 1ns/1ps
`default_nettype none
module siwc_irq_src
(
	input wire logic	i_clk,
	input wire logic	i_sys_rst,
	input wire logic [7:0]	i_raise,
	input wire logic	i_drop_all,
	input wire logic	i_ack,
	input wire logic [2:0]	i_ack_idx,
	output logic [7:0]	o_irq_req
);
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst || i_drop_all)
			o_irq_req <= '0;
		else if (i_ack)
			o_irq_req <= (o_irq_req | i_raise) & ~(8'h01 << i_ack_idx);
		else
			o_irq_req <= o_irq_req | i_raise;
	end
endmodule : siwc_irq_src
`default_nettype wire

//--- siwc_top_test.sv
// self-checking bench for the sub-idle wake control
`timescale 1ns/1ps
`default_nettype none
module siwc_top_test;
	logic	i_clk = 1'b0;
	logic	i_sys_rst = 1'b1;
	logic	psel = 1'b0;
	logic	penable = 1'b0;
	logic	pwrite = 1'b0;
	logic [11:0]	paddr = '0;
	logic [31:0]	pwdata = '0;
	logic [3:0]	pstrb = '0;
	logic [31:0]	prdata;
	logic	pready;
	logic	pslverr;
	logic	i_subclock_mode = 1'b1;
	logic	i_main_clk_stopped = 1'b0;
	logic	i_pin_nmi_req = 1'b0;
	logic	i_wdt_nmi_req = 1'b0;
	logic [7:0]	i_irq_req;
	logic [7:0]	i_irq_mask = '0;
	logic [23:0]	i_irq_prio = '0;
	logic	i_in_service = 1'b0;
	logic [2:0]	i_service_prio = '0;
	logic	i_irq_globally_on = 1'b0;
	logic	o_in_sub_idle;
	logic	o_return_subclock;
	logic	o_wake;
	siwc_pkg::siwc_wake_type	o_wake_info;
	logic	o_ack;
	logic [2:0]	o_ack_idx;
	siwc_pkg::siwc_run_type	o_run;
	logic [7:0]	raise = '0;
	logic [3:0]	strb = 4'hf;
	logic	drop = 1'b0;
	logic [31:0]	r;
	logic	e;
	logic [7:0]	ex;
	siwc_pkg::siwc_clksel_type	cs;
	int	failures = 0;
	int	num_checks = 0;

	always #5 i_clk = ~i_clk;

	siwc_top DUT
	(
		.i_clk, .i_sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .i_subclock_mode, .i_main_clk_stopped, .i_pin_nmi_req,
		.i_wdt_nmi_req, .i_irq_req, .i_irq_mask, .i_irq_prio, .i_in_service,
		.i_service_prio, .i_irq_globally_on, .o_in_sub_idle, .o_return_subclock, .o_wake,
		.o_wake_info, .o_ack, .o_ack_idx, .o_run
	);

	siwc_irq_src u_src
	(
		.i_clk, .i_sys_rst, .i_raise(raise), .i_drop_all(drop), .i_ack(o_ack),
		.i_ack_idx(o_ack_idx), .o_irq_req(i_irq_req)
	);

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
	begin
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	end
	endtask : chk

	task automatic complete_run;
	begin
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask : complete_run

	task automatic timed_out;
	begin
		failures++;
		complete_run();
	end
	endtask : timed_out

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
	begin
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= strb;
		@(posedge i_clk);
		penable <= 1'b1;
		@(posedge i_clk);
		while (pready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge i_clk);
		end
		if (n == 20)
			timed_out();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge i_clk);
	end
	endtask : apb

	task automatic wait_wake;
		int n;
	begin
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (o_wake !== 1'b1 && n < 20);
		if (o_wake !== 1'b1)
			timed_out();
	end
	endtask : wait_wake

	// idx, branch, resume, acked nmi, cause of a maskable wake
	function automatic logic [7:0] exp_wake(input logic [7:0] q, input logic [7:0] m);
		logic [2:0] bi;
		logic [2:0] bp;
		logic f;
		logic tk;
	begin
		f = 1'b0;
		bi = '0;
		bp = '0;
		for (int i = 0; i < 8; i++)
			if (q[i] && !m[i] && (!f || i_irq_prio[3*i+:3] < bp))
			begin
				f = 1'b1;
				bi = 3'(i);
				bp = i_irq_prio[3*i+:3];
			end
		tk = i_irq_globally_on && (!i_in_service || bp < i_service_prio);
		return {bi, tk, !tk, 1'b0, siwc_pkg::CAUSE_MASKABLE};
	end
	endfunction : exp_wake

	function automatic siwc_pkg::siwc_run_type exp_run(input siwc_pkg::siwc_clksel_type c,
		input logic ms);
		siwc_pkg::siwc_run_type x;
	begin
		x = '0;
		x.wdt_two = 1'b1;
		x.key_irq = 1'b1;
		x.dac_drive = 1'b1;
		x.watch_timer = !ms || c.watch_timer_on_subclock;
		x.wide_timer_one = c.wide_timer_one_from_watch_irq && x.watch_timer;
		x.byte_timer[0] = c.byte_timer_a_ext_input
			|| (c.byte_timer_a_from_compare && x.wide_timer_one);
		x.byte_timer[1] = c.byte_timer_b_ext_input
			|| (c.byte_timer_b_from_compare && x.wide_timer_one);
		x.interval_timer_b = c.interval_timer_b_fr_2048;
		x.serial_sync = c.serial_ext_clock;
		x.async0 = c.async0_ext_baud;
		x.rto = c.rto_trig_byte_timer_irq && x.byte_timer[c.rto_uses_byte_timer_b];
		return x;
	end
	endfunction : exp_run

	initial
	begin
		void'($urandom(34829));
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		apb(1'b0, siwc_pkg::OFF_STATUS, '0);
		chk("status", r, 32'({siwc_pkg::RUN_ALL, 7'h00}));
		apb(1'b0, 12'h010, '0);
		chk("unmapped", {r[30:0], e}, 32'h1);
		apb(1'b1, siwc_pkg::OFF_STANDBY_CTRL, 32'h3);
		chk("stop select", o_in_sub_idle, 1'b0);
		i_subclock_mode <= 1'b0;
		apb(1'b1, siwc_pkg::OFF_STANDBY_CTRL, 32'h2);
		chk("not subclock", o_in_sub_idle, 1'b0);
		i_subclock_mode <= 1'b1;
		strb = 4'he;
		apb(1'b1, siwc_pkg::OFF_STANDBY_CTRL, 32'h2);
		chk("no lane 0", o_in_sub_idle, 1'b0);
		strb = 4'hf;
		apb(1'b1, siwc_pkg::OFF_STANDBY_CTRL, 32'h1e);
		i_pin_nmi_req <= 1'b1;
		i_wdt_nmi_req <= 1'b1;
		raise <= 8'h01;
		@(posedge i_clk);
		raise <= 8'h00;
		repeat (6) @(posedge i_clk);
		chk("masked", {o_in_sub_idle, o_wake}, 2'b10);
		apb(1'b0, siwc_pkg::OFF_STANDBY_CTRL, '0);
		chk("ctrl", r, 32'h1c);
		apb(1'b1, siwc_pkg::OFF_STANDBY_CTRL, '0);
		wait_wake();
		chk("pin nmi", o_wake_info, {3'b101, siwc_pkg::CAUSE_PIN_NMI});
		i_pin_nmi_req <= 1'b0;
		i_wdt_nmi_req <= 1'b0;
		drop <= 1'b1;
		@(posedge i_clk);
		drop <= 1'b0;
		apb(1'b0, siwc_pkg::OFF_WAKE_CAUSE, '0);
		chk("cause", r, 32'(siwc_pkg::CAUSE_PIN_NMI));
		for (int k = 0; k < 24; k++)
		begin
			i_irq_prio <= 24'($urandom);
			i_irq_mask <= 8'($urandom) & ~(8'h01 << k % 8);
			i_irq_globally_on <= 1'($urandom);
			i_in_service <= 1'($urandom);
			i_service_prio <= 3'($urandom);
			apb(1'b1, siwc_pkg::OFF_STANDBY_CTRL, 32'h2);
			raise <= 8'($urandom) | (8'h01 << k % 8);
			@(posedge i_clk);
			raise <= 8'h00;
			wait_wake();
			ex = exp_wake(i_irq_req, i_irq_mask);
			chk("wake info", o_wake_info, ex[4:0]);
			chk("ack", {o_ack, o_return_subclock}, {ex[4], 1'b1});
			if (ex[4])
				chk("ack idx", o_ack_idx, ex[7:5]);
			@(posedge i_clk);
			chk("pending", i_irq_req[ex[7:5]], !ex[4]);
			drop <= 1'b1;
			@(posedge i_clk);
			drop <= 1'b0;
		end
		for (int k = 0; k < 12; k++)
		begin
			cs = 13'($urandom);
			i_main_clk_stopped <= 1'($urandom);
			apb(1'b1, siwc_pkg::OFF_CLK_SELECT, 32'(cs));
			apb(1'b0, siwc_pkg::OFF_CLK_SELECT, '0);
			chk("clksel", r, 32'(cs));
			apb(1'b1, siwc_pkg::OFF_STANDBY_CTRL, 32'h2);
			chk("run", o_run, exp_run(cs, i_main_clk_stopped));
			i_wdt_nmi_req <= 1'b1;
			wait_wake();
			chk("wdt nmi", o_wake_info, {3'b101, siwc_pkg::CAUSE_WDT_NMI});
			i_wdt_nmi_req <= 1'b0;
		end
		apb(1'b1, siwc_pkg::OFF_STANDBY_CTRL, 32'h2);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(posedge i_clk);
		chk("after reset", {o_in_sub_idle, o_return_subclock}, 2'b00);
		apb(1'b0, siwc_pkg::OFF_CLK_SELECT, '0);
		chk("clksel reset", r, '0);
		complete_run();
	end
endmodule : siwc_top_test
`default_nettype wire
